/* include/ybp_pkg.sv */
// shared types and constants for the yuv 4:2:2 byte packer
package ybp_pkg;

  // coding identifiers selecting the byte order
  localparam logic [7:0] CODE_STD = 8'h02; // chroma-first order
  localparam logic [7:0] CODE_ALT = 8'h85; // luma_first_422_order

  // chroma offset and the value sent for chroma on a monochrome sensor
  localparam logic [7:0] CHROMA_OFS = 8'h80;
  localparam logic [7:0] MONO_CHROMA = 8'h00;

  // bit position of the sign in a chroma sample
  localparam int CHROMA_SIGN_BIT = 7;

  // colour-space weights in 1/256 units, each row of chroma sums to zero
  localparam int COEF_SHIFT = 8;
  localparam logic signed [9:0] Y_R = 10'sh04D; // 0.30
  localparam logic signed [9:0] Y_G = 10'sh097; // 0.59
  localparam logic signed [9:0] Y_B = 10'sh01C; // 0.11
  localparam logic signed [9:0] U_R = -10'sh02C; // -0.17
  localparam logic signed [9:0] U_G = -10'sh054; // -0.33
  localparam logic signed [9:0] U_B = 10'sh080; // 0.50
  localparam logic signed [9:0] V_R = 10'sh080; // 0.50
  localparam logic signed [9:0] V_G = -10'sh069; // -0.41
  localparam logic signed [9:0] V_B = -10'sh017; // -0.09

  // byte slots of one pixel pair
  localparam logic [1:0] SLOT_FIRST = 2'h0;
  localparam logic [1:0] SLOT_LAST = 2'h3;

  // interpolated colour pixel from the pipeline
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } ybp_rgb_t;

  // converted pixel: unsigned luma, signed chroma
  typedef struct packed {
    logic [7:0] y;
    logic signed [7:0] u;
    logic signed [7:0] v;
  } ybp_yuv_t;

  // stream markers that travel with a pixel
  typedef struct packed {
    logic sof;
    logic sol;
    logic eol;
  } ybp_mark_t;

  // which sample a byte slot carries
  typedef enum logic [1:0] {
    SEL_Y0 = 2'b00,
    SEL_Y1 = 2'b01,
    SEL_U = 2'b10,
    SEL_V = 2'b11
  } ybp_sel_t;

  // pair assembly states
  typedef enum logic [1:0] {
    ST_EVEN = 2'b00,
    ST_ODD = 2'b01,
    ST_SEND = 2'b10
  } ybp_state_t;

endpackage : ybp_pkg

/* src/ybp_chroma_enc.sv */
`timescale 1ns/1ns
`default_nettype none
// signed chroma sample to the transmitted offset-binary byte
module ybp_chroma_enc (
  input wire logic signed [7:0] sample_in, // chroma, -128..127
  input wire logic mono_in, // monochrome sensor in use
  output logic [7:0] byte_out // transmitted chroma byte
);

  logic [7:0] offset_byte;

  // adding 128 modulo 256 is a flip of the sign bit, so no carry chain
  assign offset_byte = sample_in + ybp_pkg::CHROMA_OFS;

  // monochrome keeps the slot but sends a constant
  assign byte_out = mono_in ? ybp_pkg::MONO_CHROMA : offset_byte;

endmodule : ybp_chroma_enc
`default_nettype wire

/* src/ybp_csc.sv */
`timescale 1ns/1ns
`default_nettype none
// rgb to yuv, fixed point with weights rounded to 1/256
module ybp_csc (
  input wire ybp_pkg::ybp_rgb_t rgb_in, // interpolated colour pixel
  output ybp_pkg::ybp_yuv_t yuv_out // luma unsigned, chroma signed
);

  logic signed [19:0] y_sum;
  logic signed [19:0] u_sum;
  logic signed [19:0] v_sum;
  logic signed [9:0] r_s;
  logic signed [9:0] g_s;
  logic signed [9:0] b_s;

  // zero-extend so the products stay signed
  assign r_s = signed'({2'b00, rgb_in.r});
  assign g_s = signed'({2'b00, rgb_in.g});
  assign b_s = signed'({2'b00, rgb_in.b});

  // weighted sums; floor by arithmetic shift keeps chroma in -128..127
  assign y_sum = ybp_pkg::Y_R * r_s + ybp_pkg::Y_G * g_s + ybp_pkg::Y_B * b_s;
  assign u_sum = ybp_pkg::U_R * r_s + ybp_pkg::U_G * g_s + ybp_pkg::U_B * b_s;
  assign v_sum = ybp_pkg::V_R * r_s + ybp_pkg::V_G * g_s + ybp_pkg::V_B * b_s;

  assign yuv_out.y = y_sum[15:8];
  assign yuv_out.u = u_sum[15:8];
  assign yuv_out.v = v_sum[15:8];

endmodule : ybp_csc
`default_nettype wire

/* src/ybp_packer.sv */
// Operation
// - chroma sample gets 128 added, sent as 0..255
// - coding 2 sends U, Y even, V, Y odd per pair
// - luma per pixel; one U and V per pair from the even pixel
// - coding 133 sends Y even, U, Y odd, V per pair
// - luma is an unsigned byte, 0x00 to 0xFF linear
// - chroma bytes are offset binary, 0x80 is zero
// - both codings carry identical samples, only positions differ
// - monochrome luma equals the plain 8-bit brightness value
// - monochrome chroma bytes are zero in their usual positions
// - monochrome follows the byte order of the selected coding
// - colour luma and chroma come from fixed rgb weights
// - pixels leave in arrival order, row by row, left to right
`timescale 1ns/1ns
`default_nettype none
module ybp_packer (
  input wire logic clk_sys_in, // 25 MHz pixel clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic [7:0] coding_in, // coding identifier, 2 or 133
  input wire logic mono_in, // monochrome sensor fitted
  input wire logic pix_valid_in, // pixel offered
  input wire ybp_pkg::ybp_rgb_t pix_rgb_in, // colour pixel
  input wire logic [7:0] pix_mono_in, // monochrome brightness
  input wire ybp_pkg::ybp_mark_t pix_mark_in, // frame and line markers
  output logic pix_ready_out, // pixel taken when valid and ready
  output logic [7:0] byte_out, // transmitted byte
  output logic byte_valid_out, // byte present
  output logic byte_sof_out, // first byte of a frame
  output logic byte_sol_out, // first byte of a line
  output logic byte_eol_out, // last byte of a line
  input wire logic byte_ready_in // host path takes the byte
);

  ////////////////////////////////////////////////////////////////
  // declarations

  ybp_pkg::ybp_state_t state_reg;
  ybp_pkg::ybp_state_t state_next;
  ybp_pkg::ybp_yuv_t csc_yuv;
  ybp_pkg::ybp_yuv_t pix_yuv;
  ybp_pkg::ybp_mark_t even_mark_reg;
  ybp_pkg::ybp_mark_t odd_mark_reg;
  ybp_pkg::ybp_sel_t slot_sel;
  logic [7:0] y0_reg;
  logic [7:0] y1_reg;
  logic signed [7:0] u_reg;
  logic signed [7:0] v_reg;
  logic alt_order_reg;
  logic mono_pair_reg;
  logic [1:0] slot_reg;
  logic pix_ready_reg;
  logic [7:0] byte_reg;
  logic byte_valid_reg;
  logic byte_sof_reg;
  logic byte_sol_reg;
  logic byte_eol_reg;
  logic pix_take;
  logic take_even;
  logic take_odd;
  logic out_free;
  logic send_byte;
  logic pair_done;
  logic alt_sel;
  logic [7:0] u_byte;
  logic [7:0] v_byte;
  logic [7:0] slot_byte;

  ////////////////////////////////////////////////////////////////
  // pixel conversion

  // colour path through the weighted sums
  ybp_csc u_csc (
    .rgb_in(pix_rgb_in),
    .yuv_out(csc_yuv)
  );

  // monochrome luma is the brightness byte untouched
  assign pix_yuv.y = mono_in ? pix_mono_in : csc_yuv.y;
  assign pix_yuv.u = mono_in ? 8'sh00 : csc_yuv.u;
  assign pix_yuv.v = mono_in ? 8'sh00 : csc_yuv.v;

  ////////////////////////////////////////////////////////////////
  // input handshake and pair assembly

  // ready is registered, so a pixel is only taken in an assembly state
  assign pix_take = pix_valid_in & pix_ready_reg;

  // a line-start pixel always lands in the even slot
  assign take_even = pix_take & ((state_reg == ybp_pkg::ST_EVEN) | pix_mark_in.sol);
  assign take_odd = pix_take & (state_reg == ybp_pkg::ST_ODD) & ~pix_mark_in.sol;

  // output register may load when empty or being drained
  assign out_free = ~byte_valid_reg | byte_ready_in;
  assign send_byte = (state_reg == ybp_pkg::ST_SEND) & out_free;
  assign pair_done = send_byte & (slot_reg == ybp_pkg::SLOT_LAST);

  // next state; an odd-length line drops the lone even pixel
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ybp_pkg::ST_EVEN: begin
        if (take_even) begin
          state_next = ybp_pkg::ST_ODD;
        end
      end
      ybp_pkg::ST_ODD: begin
        if (take_odd) begin
          state_next = ybp_pkg::ST_SEND;
        end
      end
      ybp_pkg::ST_SEND: begin
        if (pair_done) begin
          state_next = ybp_pkg::ST_EVEN;
        end
      end
      default: begin
        state_next = ybp_pkg::ST_EVEN;
      end
    endcase
  end

  // state and input ready
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= ybp_pkg::ST_EVEN;
      pix_ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pix_ready_reg <= (state_next != ybp_pkg::ST_SEND);
    end
  end

  // even pixel: its luma, the pair's chroma and the pair's mode
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      y0_reg <= 8'h00;
      u_reg <= 8'sh00;
      v_reg <= 8'sh00;
      even_mark_reg <= '0;
      alt_order_reg <= 1'b0;
      mono_pair_reg <= 1'b0;
    end else if (take_even) begin
      y0_reg <= pix_yuv.y;
      u_reg <= pix_yuv.u;
      v_reg <= pix_yuv.v;
      even_mark_reg <= pix_mark_in;
      alt_order_reg <= (coding_in == ybp_pkg::CODE_ALT);
      mono_pair_reg <= mono_in;
    end
  end

  // odd pixel: luma only, its chroma is not sent
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      y1_reg <= 8'h00;
      odd_mark_reg <= '0;
    end else if (take_odd) begin
      y1_reg <= pix_yuv.y;
      odd_mark_reg <= pix_mark_in;
    end
  end

  ////////////////////////////////////////////////////////////////
  // byte selection

  // chroma bytes are built once and shared by both orders
  ybp_chroma_enc u_enc_u (
    .sample_in(u_reg),
    .mono_in(mono_pair_reg),
    .byte_out(u_byte)
  );

  ybp_chroma_enc u_enc_v (
    .sample_in(v_reg),
    .mono_in(mono_pair_reg),
    .byte_out(v_byte)
  );

  // slot to sample map; only positions differ between codings
  assign alt_sel = alt_order_reg;
  assign slot_sel = (slot_reg == 2'h0) ? (alt_sel ? ybp_pkg::SEL_Y0 : ybp_pkg::SEL_U) :
                    (slot_reg == 2'h1) ? (alt_sel ? ybp_pkg::SEL_U : ybp_pkg::SEL_Y0) :
                    (slot_reg == 2'h2) ? (alt_sel ? ybp_pkg::SEL_Y1 : ybp_pkg::SEL_V) :
                    (alt_sel ? ybp_pkg::SEL_V : ybp_pkg::SEL_Y1);

  assign slot_byte = (slot_sel == ybp_pkg::SEL_Y0) ? y0_reg :
                     (slot_sel == ybp_pkg::SEL_Y1) ? y1_reg :
                     (slot_sel == ybp_pkg::SEL_U) ? u_byte : v_byte;

  ////////////////////////////////////////////////////////////////
  // output stage

  // slot counter steps only when a byte is loaded
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      slot_reg <= ybp_pkg::SLOT_FIRST;
    end else if (pair_done) begin
      slot_reg <= ybp_pkg::SLOT_FIRST;
    end else if (send_byte) begin
      slot_reg <= slot_reg + 2'h1;
    end
  end

  // byte and markers held while ready is low
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      byte_reg <= 8'h00;
      byte_valid_reg <= 1'b0;
      byte_sof_reg <= 1'b0;
      byte_sol_reg <= 1'b0;
      byte_eol_reg <= 1'b0;
    end else if (send_byte) begin
      byte_reg <= slot_byte;
      byte_valid_reg <= 1'b1;
      byte_sof_reg <= even_mark_reg.sof & (slot_reg == ybp_pkg::SLOT_FIRST);
      byte_sol_reg <= even_mark_reg.sol & (slot_reg == ybp_pkg::SLOT_FIRST);
      byte_eol_reg <= odd_mark_reg.eol & (slot_reg == ybp_pkg::SLOT_LAST);
    end else if (out_free) begin
      byte_valid_reg <= 1'b0;
      byte_sof_reg <= 1'b0;
      byte_sol_reg <= 1'b0;
      byte_eol_reg <= 1'b0;
    end
  end

  // every output straight from a flop
  assign pix_ready_out = pix_ready_reg;
  assign byte_out = byte_reg;
  assign byte_valid_out = byte_valid_reg;
  assign byte_sof_out = byte_sof_reg;
  assign byte_sol_out = byte_sol_reg;
  assign byte_eol_out = byte_eol_reg;

endmodule : ybp_packer
`default_nettype wire

/* verif/test_ybp_packer.sv */
`timescale 1ns/1ns
`default_nettype none
module test_ybp_packer;
  typedef struct {
    logic [7:0] code;
    logic mono;
    logic [23:0] c0;
    logic [23:0] c1;
    logic [15:0] m01;
    logic [31:0] e;
  } ybp_row_t;
  // grey, pure colours, chroma extremes and mono, in both orders
  ybp_row_t rows [7] = '{
    '{8'h02, 1'b0, 24'h404040, 24'h414141, 16'h0000, 32'h80408041},
    '{8'h85, 1'b0, 24'h404040, 24'h414141, 16'h0000, 32'h40804180},
    '{8'h02, 1'b0, 24'h0000FF, 24'h000000, 16'h0000, 32'hFF1B6900},
    '{8'h85, 1'b0, 24'hFF0000, 24'h00FF00, 16'h0000, 32'h4C5496FF},
    '{8'h02, 1'b1, 24'h121212, 24'h343434, 16'hFF00, 32'h00FF0000},
    '{8'h85, 1'b1, 24'h121212, 24'h343434, 16'h01FE, 32'h0100FE00},
    '{8'h02, 1'b0, 24'hFFFF00, 24'h808080, 16'h0000, 32'h00E39680}};
  ybp_row_t r;
  logic clk_sys_in, rst_b_in, mono_in, pix_valid_in, byte_ready_in, slow;
  logic [7:0] coding_in, pix_mono_in, byte_out;
  ybp_pkg::ybp_rgb_t pix_rgb_in;
  ybp_pkg::ybp_mark_t pix_mark_in;
  logic pix_ready_out, byte_valid_out, byte_sof_out, byte_sol_out, byte_eol_out;
  int error_cnt = 0;
  int total_checks = 0;
  ybp_packer ybp_packer_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .coding_in(coding_in), .mono_in(mono_in), .pix_valid_in(pix_valid_in),
    .pix_rgb_in(pix_rgb_in), .pix_mono_in(pix_mono_in), .pix_mark_in(pix_mark_in),
    .pix_ready_out(pix_ready_out), .byte_out(byte_out), .byte_valid_out(byte_valid_out),
    .byte_sof_out(byte_sof_out), .byte_sol_out(byte_sol_out), .byte_eol_out(byte_eol_out),
    .byte_ready_in(byte_ready_in));
  ybp_host ybp_host_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .byte_in(byte_out),
    .valid_in(byte_valid_out), .mark_in({byte_sof_out, byte_sol_out, byte_eol_out}),
    .slow_in(slow), .ready_out(byte_ready_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [10:0] got, input logic [10:0] e);
    total_checks++;
    if (got !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask : cmp
  // holds valid until taken; caller drops it, never in the same step
  task automatic px(input logic [23:0] c, input logic [7:0] m, input logic [2:0] k);
    int n;
    pix_valid_in = 1'b1;
    pix_rgb_in = c;
    pix_mono_in = m;
    pix_mark_in = k;
    n = 0;
    while (pix_ready_out !== 1'b1 && n < 100) begin
      @(negedge clk_sys_in);
      n++;
    end
    @(negedge clk_sys_in);
  endtask : px
  task automatic expect4(input logic [43:0] e);
    int n;
    pix_valid_in = 1'b0;
    n = 0;
    while (ybp_host_inst.got_q.size() < 4 && n < 100) begin
      @(negedge clk_sys_in);
      n++;
    end
    for (int k = 0; k < 4; k++) begin
      cmp(ybp_host_inst.got_q.size() ? ybp_host_inst.got_q.pop_front() : 11'hXXX,
        e[43 - 11 * k -: 11]);
    end
  endtask : expect4
  function automatic logic [43:0] wide(input logic [31:0] b);
    return {3'h0, b[31:24], 3'h0, b[23:16], 3'h0, b[15:8], 3'h0, b[7:0]};
  endfunction : wide
  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  // whole run needs well under a thousand cycles
  initial begin
    #400000;
    error_cnt++;
    results();
  end
  initial begin
    {rst_b_in, mono_in, pix_valid_in, slow, coding_in, pix_mono_in} = '0;
    pix_rgb_in = '0;
    pix_mark_in = '0;
    repeat (3) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    // second pass throttles the host so the last three bytes of each pair must hold
    for (int i = 0; i < 14; i++) begin
      r = rows[i % 7];
      slow = (i >= 7);
      coding_in = r.code;
      mono_in = r.mono;
      px(r.c0, r.m01[15:8], 3'h0);
      px(r.c1, r.m01[7:0], 3'h0);
      expect4(wide(r.e));
    end
    // lone even pixel dropped at a new line, markers ride first and last bytes
    slow = 1'b0;
    coding_in = ybp_pkg::CODE_STD;
    mono_in = 1'b0;
    px(24'h050505, 8'h00, 3'h2);
    px(24'h101010, 8'h00, 3'h6);
    px(24'h202020, 8'h00, 3'h1);
    expect4({3'h6, 8'h80, 3'h0, 8'h10, 3'h0, 8'h80, 3'h1, 8'h20});
    // reset in the middle of a pair clears the outputs at once
    px(24'h303030, 8'h00, 3'h0);
    px(24'h404040, 8'h00, 3'h0);
    pix_valid_in = 1'b0;
    @(negedge clk_sys_in);
    rst_b_in = 1'b0;
    #1 cmp({pix_ready_out, byte_valid_out, byte_sol_out, byte_out}, 11'h000);
    @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    r = rows[1];
    coding_in = r.code;
    px(r.c0, 8'h00, 3'h0);
    px(r.c1, 8'h00, 3'h0);
    expect4(wide(r.e));
    results();
  end
endmodule : test_ybp_packer
`default_nettype wire

/* verif/ybp_host.sv */
`timescale 1ns/1ns
`default_nettype none
// host receive side, collects markers and bytes
module ybp_host (
  input wire logic clk_sys_in, // clock
  input wire logic rst_b_in, // reset
  input wire logic [7:0] byte_in, // byte
  input wire logic valid_in, // byte valid
  input wire ybp_pkg::ybp_mark_t mark_in, // markers
  input wire logic slow_in, // throttle
  output logic ready_out // takes byte
);
  logic [1:0] cnt_reg; // throttle phase
  logic [10:0] got_q [$]; // taken markers and bytes
  // slow host is ready one cycle in four so each byte after the first of a pair sees a stall
  assign ready_out = !slow_in || cnt_reg == 2'h0;
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg <= 2'h0;
      got_q.delete();
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      if (valid_in && ready_out) got_q.push_back({mark_in, byte_in});
    end
  end
endmodule : ybp_host
`default_nettype wire

/* verif/ybp_packer_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// port-level watch on pair timing, stalls and slot contents
module ybp_packer_chk (
  input wire logic clk_sys_in, // clock
  input wire logic rst_b_in, // reset
  input wire logic [7:0] coding_in, // coding
  input wire logic mono_in, // mono
  input wire logic pix_valid_in, // pixel valid
  input wire ybp_pkg::ybp_mark_t pix_mark_in, // markers
  input wire logic pix_ready_out, // pixel ready
  input wire logic [7:0] byte_out, // byte
  input wire logic byte_valid_out, // byte valid
  input wire logic byte_sof_out, // frame start
  input wire logic byte_sol_out, // line start
  input wire logic byte_eol_out, // line end
  input wire logic byte_ready_in // host ready
);
  logic [1:0] slot_reg; // slot of the byte on show
  logic odd_reg; // next pixel is odd
  wire take_px = pix_valid_in && pix_ready_out;
  wire take_b = byte_valid_out && byte_ready_in;
  wire chroma_slot = (coding_in == ybp_pkg::CODE_ALT) ? slot_reg[0] : !slot_reg[0];
  // a line-start pixel always opens a pair, so parity restarts
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      slot_reg <= 2'h0;
      odd_reg <= 1'b0;
    end else begin
      if (take_b) slot_reg <= slot_reg + 2'h1;
      if (take_px) odd_reg <= pix_mark_in.sol | ~odd_reg;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  sequence odd_take;
    take_px && odd_reg && !pix_mark_in.sol;
  endsequence
  sequence full_run;
    take_b [*3] ##1 (take_b && slot_reg == 2'h3);
  endsequence
  a_ready_drop: assert property (odd_take |=> !pix_ready_out [*3])
    else $error("pixel ready not dropped");
  // the pair is buffered first, so the first byte shows two edges after the odd take
  a_first_byte: assert property (odd_take |=> ##1 byte_valid_out)
    else $error("no byte after pair");
  a_byte_hold: assert property (take_b == 0 && byte_valid_out |=> $stable(byte_out))
    else $error("byte moved while stalled");
  a_marks_hold: assert property (byte_valid_out && !byte_ready_in |=>
    byte_valid_out && $stable({byte_sof_out, byte_sol_out, byte_eol_out}))
    else $error("markers moved while stalled");
  a_four_only: assert property (full_run |=> !byte_valid_out)
    else $error("extra byte after pair");
  a_mono_zero: assert property (byte_valid_out && mono_in && chroma_slot |->
    byte_out == ybp_pkg::MONO_CHROMA)
    else $error("mono chroma not zero");
  a_start_first: assert property (byte_sof_out || byte_sol_out |->
    byte_valid_out && slot_reg == 2'h0)
    else $error("start marker off first slot");
  a_eol_last: assert property (byte_eol_out |-> byte_valid_out && slot_reg == 2'h3)
    else $error("end marker off last slot");
endmodule : ybp_packer_chk
bind ybp_packer ybp_packer_chk ybp_packer_chk_inst (.clk_sys_in(clk_sys_in),
  .rst_b_in(rst_b_in), .coding_in(coding_in), .mono_in(mono_in),
  .pix_valid_in(pix_valid_in), .pix_mark_in(pix_mark_in), .pix_ready_out(pix_ready_out),
  .byte_out(byte_out), .byte_valid_out(byte_valid_out), .byte_sof_out(byte_sof_out),
  .byte_sol_out(byte_sol_out), .byte_eol_out(byte_eol_out), .byte_ready_in(byte_ready_in));
`default_nettype wire
